//--- epiu_pkg.sv
// Constants, types and register map for the external pin interrupt unit.
// Assumes a single always-running clock shared by the detectors and the register port.
package epiu_pkg;

	localparam int PIN_COUNT = 28;

	// Register byte addresses on the plain register port
	localparam logic [7:0] ADDR_PC_FLAGS = 8'h1B;
	localparam logic [7:0] ADDR_EXT_FLAGS = 8'h1C;
	localparam logic [7:0] ADDR_EXT_MASK = 8'h1D;
	localparam logic [7:0] ADDR_PC_CTRL = 8'h68;
	localparam logic [7:0] ADDR_SENSE = 8'h69;
	localparam logic [7:0] ADDR_PC_MASK0 = 8'h6B;
	localparam logic [7:0] ADDR_PC_MASK1 = 8'h6C;
	localparam logic [7:0] ADDR_PC_MASK2 = 8'h6D;
	localparam logic [7:0] ADDR_PC_MASK3 = 8'h73;

	// Implemented bits per register; all others read zero and ignore writes
	localparam logic [7:0] WMASK_SENSE = 8'h03;
	localparam logic [7:0] WMASK_EXT_MASK = 8'h01;
	localparam logic [7:0] WMASK_EXT_FLAGS = 8'h01;
	localparam logic [7:0] WMASK_PC_CTRL = 8'h0F;
	localparam logic [7:0] WMASK_PC_FLAGS = 8'h0F;
	localparam logic [7:0] WMASK_PC_MASK0 = 8'h0F;
	localparam logic [7:0] WMASK_PC_MASK1 = 8'h08;
	localparam logic [7:0] WMASK_PC_MASK2 = 8'hF7;
	localparam logic [7:0] WMASK_PC_MASK3 = 8'h0F;
	localparam logic [7:0] REG_RESET = 8'h00;

	// Field positions
	localparam int SENSE_SEL_LO = 0;
	localparam int SENSE_SEL_HI = 1;
	localparam int EXT_ENABLE_BIT = 0;
	localparam int EXT_FLAG_BIT = 0;
	localparam int GROUP3_ENABLE_BIT = 3;
	localparam int EXT_SYNC_BIT = 28;

	// Pins belonging to each pin-change group
	localparam logic [27:0] GROUP0_PINS = 28'h000_000F;
	localparam logic [27:0] GROUP1_PINS = 28'h000_0800;
	localparam logic [27:0] GROUP2_PINS = 28'h0FF_0000;
	localparam logic [27:0] GROUP3_PINS = 28'hF00_0000;

	// Vector numbers and word addresses
	localparam logic [5:0] VEC_EXT = 6'h02;
	localparam logic [5:0] VEC_GROUP0 = 6'h06;
	localparam logic [5:0] VEC_GROUP1 = 6'h07;
	localparam logic [5:0] VEC_GROUP2 = 6'h08;
	localparam logic [5:0] VEC_CARD = 6'h25;
	localparam logic [5:0] VEC_GROUP3 = 6'h26;
	localparam logic [15:0] WADDR_EXT = 16'h0002;
	localparam logic [15:0] WADDR_GROUP0 = 16'h000A;
	localparam logic [15:0] WADDR_GROUP1 = 16'h000C;
	localparam logic [15:0] WADDR_GROUP2 = 16'h000E;
	localparam logic [15:0] WADDR_CARD = 16'h0048;
	localparam logic [15:0] WADDR_GROUP3 = 16'h004A;

	// Cycles after reset before synchroniser output is trusted
	localparam logic [1:0] SETTLE_CYCLES = 2'h3;

	typedef enum logic [1:0] {
		SENSE_LOW = 2'b00,
		SENSE_ANY = 2'b01,
		SENSE_FALL = 2'b10,
		SENSE_RISE = 2'b11
	} epiu_sense_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} epiu_bus_s;

	typedef struct packed {
		logic ext;
		logic [3:0] group;
	} epiu_ack_s;

	typedef struct packed {
		logic ext_request_irq;
		logic pin_change_group0_irq;
		logic pin_change_group1_irq;
		logic pin_change_group2_irq;
		logic card_presence_irq;
		logic pin_change_group3_irq;
	} epiu_irq_s;

endpackage

//--- epiu_core.sv
// External pin interrupt unit: one sense-configurable request pin, four pin-change groups,
// register port, request gating and vector selection.
// Assumes clk keeps running in sleep (detector clock), and that ack pulses come from the
// core's vector logic on the same clock.
//
// Overview of operation
// - Pins raise interrupts even when driven as outputs, enabling software interrupts.
// - Group 3 pins 27:24, group 2 pins 23:16, group 1 pin 11, group 0 pins 3:0.
// - Pin-change detection keeps working in sleep, so it can wake the device.
// - Two-bit sense field: low level, any edge, falling edge, rising edge.
// - Low-level mode keeps the external request asserted while the pin stays low.
// - External level and edge detection work during sleep and can wake the device.
// - Low level waking from power-down must persist; otherwise wake without interrupt.
// - External interrupt needs both global enable and its mask bit 0.
// - Selected edge sets the external flag; vectoring also needs both enables.
// - External flag clears on handler entry or on writing one.
// - In low-level mode the external flag always reads cleared.
// - Sleep with external interrupt disabled gates its input, possibly setting the flag.
// - Group 3 enable bit 3 plus global enable lets masked group 3 pins interrupt.
// - Card presence vector 37 at 0048, group 3 vector 38 at 004A.
// - External vector 2 at 0002; groups 0..2 vectors 6..8 at 000A..000E.
// - Change on enabled group pin sets group flag; handler or write-one clears.
// - A pin counts only with its mask bit and its group enable set.
`timescale 1ns/1ps

module epiu_core (
	input wire logic clk, // Detector and register clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic ce, // Clock enable, freezes all state when low
	input wire epiu_pkg::epiu_bus_s bus, // Register port request
	output logic [7:0] rdata, // Read data, valid the cycle after a read
	input wire logic ext_request_pin, // External request pin
	input wire logic [epiu_pkg::PIN_COUNT-1:0] pin_change_inputs, // Pin-change pins
	input wire logic global_int_enable, // Global enable from core_status_reg
	input wire logic sleep_active, // Device is in a sleep mode
	input wire logic card_presence_req, // Card presence request, same clock
	input wire epiu_pkg::epiu_ack_s ack, // Handler entry pulses
	output epiu_pkg::epiu_irq_s irq, // Gated requests per source
	output logic irq_pending, // Any gated request present
	output logic [5:0] irq_vector, // Vector number of highest priority request
	output logic [15:0] irq_word_addr, // Word address of that vector
	output logic wake_req // Wake-up request to sleep control
);
	import epiu_pkg::*;

	localparam int SYNC_W = PIN_COUNT + 1;

	// Edge test for the selected sense mode; low level yields no edge
	function automatic logic sense_edge(input epiu_sense_e mode, input logic prev, input logic cur);
		logic hit;
		hit = 1'b0;
		case (mode)
			SENSE_ANY: hit = prev ^ cur;
			SENSE_FALL: hit = prev & ~cur;
			SENSE_RISE: hit = ~prev & cur;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Group hit from masked changes and the group's enable bit
	function automatic logic group_hit(input logic [27:0] contrib, input logic [27:0] pins, input logic en);
		return en & (|(contrib & pins));
	endfunction

	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [SYNC_W-1:0] sync3_reg;
	logic [SYNC_W-1:0] filt_reg;
	logic [SYNC_W-1:0] filt_next;
	logic [1:0] settle_reg;
	logic armed_reg;
	logic ext_int_reg;
	logic ext_int_next;

	logic [7:0] sense_reg;
	logic [7:0] ext_mask_reg;
	logic [7:0] pc_ctrl_reg;
	logic [7:0] pc_mask0_reg;
	logic [7:0] pc_mask1_reg;
	logic [7:0] pc_mask2_reg;
	logic [7:0] pc_mask3_reg;
	logic ext_flag_reg;
	logic [3:0] pc_flag_reg;
	logic [7:0] rdata_reg;

	epiu_sense_e sense_mode;
	logic ext_enabled;
	logic low_level;
	logic level_req;
	logic ext_edge;
	logic ext_flag_set;
	logic ext_flag_clr;
	logic [27:0] pin_mask_vec;
	logic [27:0] pc_contrib;
	logic [3:0] pc_set;
	logic [3:0] pc_clr;
	logic wr_ext_flags;
	logic wr_pc_flags;
	epiu_irq_s irq_next;
	epiu_irq_s irq_reg;
	logic [5:0] vec_next;
	logic [15:0] waddr_next;
	logic [5:0] vec_reg;
	logic [15:0] waddr_reg;
	logic pending_reg;
	logic wake_reg;

	// Three-stage synchroniser; pins are sampled regardless of port direction
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else if (ce) begin
			sync1_reg <= {ext_request_pin, pin_change_inputs};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// A change counts only when stages two and three agree, so one pin event gives one change
	assign filt_next = (~(sync2_reg ^ sync3_reg) & sync3_reg) | ((sync2_reg ^ sync3_reg) & filt_reg);

	// Hold off edge detection until the pipeline holds real pin levels, avoiding a false edge at reset
	always_ff @(posedge clk) begin
		if (srst) begin
			settle_reg <= '0;
			armed_reg <= 1'b0;
			filt_reg <= '0;
		end else if (ce) begin
			if (settle_reg != SETTLE_CYCLES) begin
				settle_reg <= settle_reg + 2'h1;
			end
			armed_reg <= (settle_reg == SETTLE_CYCLES);
			filt_reg <= armed_reg ? filt_next : sync3_reg;
		end
	end

	assign sense_mode = epiu_sense_e'(sense_reg[SENSE_SEL_HI:SENSE_SEL_LO]);
	assign ext_enabled = ext_mask_reg[EXT_ENABLE_BIT];

	// Input buffer is switched off in sleep when the request is disabled; reads as low
	assign ext_int_next = (sleep_active & ~ext_enabled) ? 1'b0 : filt_next[EXT_SYNC_BIT];

	always_ff @(posedge clk) begin
		if (srst) begin
			ext_int_reg <= 1'b1;
		end else if (ce) begin
			// Load the settled pin level before arming, so a pin held low gives no false edge
			if (armed_reg) begin
				ext_int_reg <= ext_int_next;
			end else if (settle_reg == SETTLE_CYCLES) begin
				ext_int_reg <= sync3_reg[EXT_SYNC_BIT];
			end
		end
	end

	assign low_level = ~ext_int_reg;
	// Level request is live: if the pin rises before service, no interrupt remains
	assign level_req = (sense_mode == SENSE_LOW) & low_level;
	assign ext_edge = armed_reg & sense_edge(sense_mode, ext_int_reg, ext_int_next);

	assign wr_ext_flags = bus.wr & (bus.addr == ADDR_EXT_FLAGS);
	assign wr_pc_flags = bus.wr & (bus.addr == ADDR_PC_FLAGS);

	assign ext_flag_set = ext_edge;
	assign ext_flag_clr = ack.ext | (wr_ext_flags & bus.wdata[EXT_FLAG_BIT]) | (sense_mode == SENSE_LOW);

	// Set wins over clear so an event in the clearing cycle survives
	always_ff @(posedge clk) begin
		if (srst) begin
			ext_flag_reg <= 1'b0;
		end else if (ce) begin
			if (ext_flag_set) begin
				ext_flag_reg <= 1'b1;
			end else if (ext_flag_clr) begin
				ext_flag_reg <= 1'b0;
			end
		end
	end

	// Pins 7:4 and 15:12 belong to no group and never contribute
	assign pin_mask_vec = {pc_mask3_reg[3:0], pc_mask2_reg, pc_mask1_reg, 4'h0, pc_mask0_reg[3:0]};
	assign pc_contrib = armed_reg ? ((filt_next[27:0] ^ filt_reg[27:0]) & pin_mask_vec) : '0;

	always_comb begin
		pc_set[0] = group_hit(pc_contrib, GROUP0_PINS, pc_ctrl_reg[0]);
		pc_set[1] = group_hit(pc_contrib, GROUP1_PINS, pc_ctrl_reg[1]);
		pc_set[2] = group_hit(pc_contrib, GROUP2_PINS, pc_ctrl_reg[2]);
		pc_set[3] = group_hit(pc_contrib, GROUP3_PINS, pc_ctrl_reg[GROUP3_ENABLE_BIT]);
	end

	assign pc_clr = ack.group | (wr_pc_flags ? (bus.wdata[3:0] & WMASK_PC_FLAGS[3:0]) : 4'h0);

	always_ff @(posedge clk) begin
		if (srst) begin
			pc_flag_reg <= 4'h0;
		end else if (ce) begin
			pc_flag_reg <= pc_set | (pc_flag_reg & ~pc_clr);
		end
	end

	// Control registers; only implemented bits are stored
	always_ff @(posedge clk) begin
		if (srst) begin
			sense_reg <= REG_RESET;
			ext_mask_reg <= REG_RESET;
			pc_ctrl_reg <= REG_RESET;
			pc_mask0_reg <= REG_RESET;
			pc_mask1_reg <= REG_RESET;
			pc_mask2_reg <= REG_RESET;
			pc_mask3_reg <= REG_RESET;
		end else if (ce && bus.wr) begin
			case (bus.addr)
				ADDR_SENSE: sense_reg <= bus.wdata & WMASK_SENSE;
				ADDR_EXT_MASK: ext_mask_reg <= bus.wdata & WMASK_EXT_MASK;
				ADDR_PC_CTRL: pc_ctrl_reg <= bus.wdata & WMASK_PC_CTRL;
				ADDR_PC_MASK0: pc_mask0_reg <= bus.wdata & WMASK_PC_MASK0;
				ADDR_PC_MASK1: pc_mask1_reg <= bus.wdata & WMASK_PC_MASK1;
				ADDR_PC_MASK2: pc_mask2_reg <= bus.wdata & WMASK_PC_MASK2;
				ADDR_PC_MASK3: pc_mask3_reg <= bus.wdata & WMASK_PC_MASK3;
				default: ;
			endcase
		end
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 8'h00;
		end else if (ce) begin
			rdata_reg <= 8'h00;
			if (bus.rd) begin
				case (bus.addr)
					ADDR_SENSE: rdata_reg <= sense_reg;
					ADDR_EXT_MASK: rdata_reg <= ext_mask_reg;
					ADDR_EXT_FLAGS: rdata_reg <= {7'h00, ext_flag_reg};
					ADDR_PC_CTRL: rdata_reg <= pc_ctrl_reg;
					ADDR_PC_FLAGS: rdata_reg <= {4'h0, pc_flag_reg};
					ADDR_PC_MASK0: rdata_reg <= pc_mask0_reg;
					ADDR_PC_MASK1: rdata_reg <= pc_mask1_reg;
					ADDR_PC_MASK2: rdata_reg <= pc_mask2_reg;
					ADDR_PC_MASK3: rdata_reg <= pc_mask3_reg;
					default: rdata_reg <= 8'h00;
				endcase
			end
		end
	end

	// Requests toward the core need the global enable as well as the source enable; card presence needs only the global enable
	always_comb begin
		irq_next.ext_request_irq = global_int_enable & ext_enabled & (ext_flag_reg | level_req);
		irq_next.pin_change_group0_irq = global_int_enable & pc_ctrl_reg[0] & pc_flag_reg[0];
		irq_next.pin_change_group1_irq = global_int_enable & pc_ctrl_reg[1] & pc_flag_reg[1];
		irq_next.pin_change_group2_irq = global_int_enable & pc_ctrl_reg[2] & pc_flag_reg[2];
		irq_next.card_presence_irq = global_int_enable & card_presence_req;
		irq_next.pin_change_group3_irq = global_int_enable & pc_ctrl_reg[GROUP3_ENABLE_BIT] & pc_flag_reg[3];
	end

	// Lowest vector number wins
	always_comb begin
		vec_next = 6'h00;
		waddr_next = 16'h0000;
		if (irq_next.ext_request_irq) begin
			vec_next = VEC_EXT;
			waddr_next = WADDR_EXT;
		end else if (irq_next.pin_change_group0_irq) begin
			vec_next = VEC_GROUP0;
			waddr_next = WADDR_GROUP0;
		end else if (irq_next.pin_change_group1_irq) begin
			vec_next = VEC_GROUP1;
			waddr_next = WADDR_GROUP1;
		end else if (irq_next.pin_change_group2_irq) begin
			vec_next = VEC_GROUP2;
			waddr_next = WADDR_GROUP2;
		end else if (irq_next.card_presence_irq) begin
			vec_next = VEC_CARD;
			waddr_next = WADDR_CARD;
		end else if (irq_next.pin_change_group3_irq) begin
			vec_next = VEC_GROUP3;
			waddr_next = WADDR_GROUP3;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			irq_reg <= '0;
			vec_reg <= 6'h00;
			waddr_reg <= 16'h0000;
			pending_reg <= 1'b0;
		end else if (ce) begin
			irq_reg <= irq_next;
			vec_reg <= vec_next;
			waddr_reg <= waddr_next;
			pending_reg <= |irq_next;
		end
	end

	// Wake ignores the global enable; sleep control decides what to do with it
	always_ff @(posedge clk) begin
		if (srst) begin
			wake_reg <= 1'b0;
		end else if (ce) begin
			wake_reg <= (ext_enabled & (ext_flag_reg | level_req)) | (|(pc_flag_reg & pc_ctrl_reg[3:0]));
		end
	end

	assign rdata = rdata_reg;
	assign irq = irq_reg;
	assign irq_pending = pending_reg;
	assign irq_vector = vec_reg;
	assign irq_word_addr = waddr_reg;
	assign wake_req = wake_reg;

endmodule

//--- epiu_core_asserts.sv
// Port checker for the external pin interrupt unit.
// Assumes one clock; bound to every epiu_core instance.
`timescale 1ns/1ps
module epiu_core_asserts
	import epiu_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic srst, // Reset
	input wire logic ce, // Clock enable
	input wire epiu_pkg::epiu_bus_s bus, // Register port
	input wire logic [7:0] rdata, // Read data
	input wire logic [27:0] pin_change_inputs, // Pins
	input wire logic global_int_enable, // Global enable
	input wire logic card_presence_req, // Card request
	input wire epiu_pkg::epiu_ack_s ack, // Entry pulses
	input wire epiu_pkg::epiu_irq_s irq, // Requests
	input wire logic irq_pending, // Any request
	input wire logic [5:0] irq_vector, // Vector
	input wire logic [15:0] irq_word_addr // Word address
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_sense_rsvd_zero: assert property ($past(bus.rd && ce) && $past(bus.addr) == ADDR_SENSE |-> rdata[7:2] == 6'h00)
		else $error("sense reserved bits read nonzero");
	a_ext_needs_gie: assert property (irq.ext_request_irq |-> $past(global_int_enable))
		else $error("external request without global enable");
	a_g3_needs_gie: assert property ($rose(irq.pin_change_group3_irq) |-> $past(global_int_enable))
		else $error("group 3 request without global enable");
	a_pending_any: assert property (irq_pending == (|irq))
		else $error("pending differs from requests");
	a_ext_vector: assert property (irq.ext_request_irq |-> irq_vector == VEC_EXT && irq_word_addr == WADDR_EXT)
		else $error("external vector wrong");
	a_g3_vector: assert property (irq_vector == VEC_GROUP3 |-> irq_word_addr == WADDR_GROUP3 && irq.pin_change_group3_irq)
		else $error("group 3 vector wrong");
	a_card_pass: assert property (card_presence_req && global_int_enable && ce |=> irq.card_presence_irq)
		else $error("card presence request lost");
	a_ack_clears: assert property (ack.group[0] && $past(pin_change_inputs[3:0], 4) == pin_change_inputs[3:0]
		|-> ##2 !irq.pin_change_group0_irq)
		else $error("group 0 request kept after entry");
endmodule

bind epiu_core epiu_core_asserts epiu_core_asserts_inst (.clk(clk), .srst(srst), .ce(ce), .bus(bus), .rdata(rdata),
	.pin_change_inputs(pin_change_inputs), .global_int_enable(global_int_enable),
	.card_presence_req(card_presence_req), .ack(ack), .irq(irq), .irq_pending(irq_pending),
	.irq_vector(irq_vector), .irq_word_addr(irq_word_addr));

//--- epiu_core_model.sv
// Far-side model: the core's vector logic that enters handlers.
// Assumes the unit's clock and its registered request outputs.
`timescale 1ns/1ps
module epiu_core_model
	import epiu_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic srst, // Reset
	input wire logic auto_en, // Take requests
	input wire logic slow, // Long instruction
	input wire logic irq_pending, // Any request
	input wire logic [5:0] irq_vector, // Vector
	output epiu_pkg::epiu_ack_s ack // Entry pulses
);
	logic [2:0] wait_reg;
	// Entry waits for the running instruction, so a short low level is missed
	always_ff @(posedge clk) begin
		ack <= '0;
		if (srst || !auto_en || !irq_pending) begin
			wait_reg <= 3'h0;
		end else if (wait_reg == (slow ? 3'h6 : 3'h2)) begin
			wait_reg <= 3'h0;
			ack.ext <= irq_vector == VEC_EXT;
			ack.group <= {irq_vector == VEC_GROUP3, irq_vector == VEC_GROUP2, irq_vector == VEC_GROUP1,
				irq_vector == VEC_GROUP0};
		end else begin
			wait_reg <= wait_reg + 3'h1;
		end
	end
endmodule

//--- tb.sv
// Testbench for the external pin interrupt unit.
// Assumes a 50 MHz clock and the core model for handler entry.
`timescale 1ns/1ps
module tb;
	import epiu_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	epiu_bus_s bus = '0;
	logic ext_pin = 1'b1;
	logic [27:0] pins = 28'h000_0000;
	logic gie = 1'b0, sleep = 1'b0, card = 1'b0, auto_en = 1'b0, slow = 1'b0, ce = 1'b1;
	epiu_ack_s ack;
	epiu_irq_s irq;
	logic pending, wake;
	logic [7:0] rdata;
	logic [5:0] vec;
	logic [15:0] waddr;
	int failures = 0;
	int samples_checked = 0;
	logic [7:0] regs [4] = '{8'h1C, 8'h1D, 8'h68, 8'h69};
	logic [7:0] wmask [4] = '{8'h00, 8'h01, 8'h0F, 8'h03};
	logic [7:0] maddr [4] = '{8'h6B, 8'h6C, 8'h6D, 8'h73};
	logic [7:0] mval [4] = '{8'h01, 8'h08, 8'h01, 8'h01};
	logic [27:0] gpin [4] = '{28'h000_0001, 28'h000_0800, 28'h001_0000, 28'h100_0000};
	logic [15:0] gvec [4] = '{16'h0006, 16'h0007, 16'h0008, 16'h0026};
	logic [15:0] gaddr [4] = '{16'h000A, 16'h000C, 16'h000E, 16'h004A};
	always #10 clk = ~clk;
	epiu_core epiu_core_inst (.clk(clk), .srst(srst), .ce(ce), .bus(bus), .rdata(rdata),
		.ext_request_pin(ext_pin), .pin_change_inputs(pins), .global_int_enable(gie), .sleep_active(sleep),
		.card_presence_req(card), .ack(ack), .irq(irq), .irq_pending(pending), .irq_vector(vec),
		.irq_word_addr(waddr), .wake_req(wake));
	epiu_core_model epiu_core_model_inst (.clk(clk), .srst(srst), .auto_en(auto_en), .slow(slow),
		.irq_pending(pending), .irq_vector(vec), .ack(ack));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 check(name, {8'h00, exp}, {8'h00, rdata});
	endtask
	task automatic wait_pend(input logic lvl);
		int i;
		for (i = 0; i < 40 && pending !== lvl; i++) @(posedge clk);
		if (i == 40) begin
			failures++;
			give_verdict();
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			rd(regs[k], 8'h00, "reset value");
			wr(regs[k], 8'hFF);
			rd(regs[k], wmask[k], "implemented bits");
			wr(regs[k], 8'h00);
		end
		wr(8'h50, 8'hFF);
		rd(8'h50, 8'h00, "unmapped");
		$display("test registers done");
		@(posedge clk) gie <= 1'b1;
		for (int g = 0; g < 4; g++) begin
			wr(maddr[g], mval[g]);
			wr(8'h68, 8'h01 << g);
			@(posedge clk) pins <= pins ^ gpin[g];
			wait_pend(1'b1);
			check("vector", gvec[g], {10'h000, vec});
			check("word address", gaddr[g], waddr);
			check("wake", 16'h0001, {15'h0000, wake});
			rd(8'h1B, 8'h01 << g, "group flag");
			wr(8'h1B, 8'hFF);
			wr(maddr[g], 8'h00);
			@(posedge clk) pins <= pins ^ gpin[g];
			repeat (8) @(posedge clk);
			rd(8'h1B, 8'h00, "masked pin flag");
		end
		$display("test groups done");
		@(posedge clk) gie <= 1'b0;
		for (int m = 1; m < 4; m++) begin
			wr(8'h1D, 8'h00);
			wr(8'h69, m[7:0]);
			wr(8'h1C, 8'h01);
			wr(8'h1D, 8'h01);
			@(posedge clk) ext_pin <= 1'b0;
			repeat (8) @(posedge clk);
			rd(8'h1C, {7'h00, m != 3}, "flag after fall");
			check("gated ext", 16'h0000, {15'h0000, irq.ext_request_irq});
			wr(8'h1C, 8'h01);
			@(posedge clk) ext_pin <= 1'b1;
			repeat (8) @(posedge clk);
			rd(8'h1C, {7'h00, m != 2}, "flag after rise");
		end
		@(posedge clk) gie <= 1'b1;
		wait_pend(1'b1);
		check("ext vector", 16'h0002, {10'h000, vec});
		@(posedge clk) auto_en <= 1'b1;
		wait_pend(1'b0);
		rd(8'h1C, 8'h00, "flag after entry");
		$display("test edges done");
		@(posedge clk) slow <= 1'b1;
		wr(8'h1D, 8'h00);
		wr(8'h69, 8'h00);
		wr(8'h1C, 8'h01);
		wr(8'h1D, 8'h01);
		@(posedge clk) ext_pin <= 1'b0;
		wait_pend(1'b1);
		repeat (20) @(posedge clk);
		check("low level held", 16'h0001, {15'h0000, irq.ext_request_irq});
		rd(8'h1C, 8'h00, "low mode flag");
		@(posedge clk) ext_pin <= 1'b1;
		wait_pend(1'b0);
		wr(8'h6B, 8'h01);
		wr(8'h68, 8'h01);
		@(posedge clk) pins <= pins ^ gpin[0];
		wait_pend(1'b1);
		wait_pend(1'b0);
		rd(8'h1B, 8'h00, "group flag after entry");
		@(posedge clk) card <= 1'b1;
		wait_pend(1'b1);
		check("card vector", 16'h0025, {10'h000, vec});
		check("card address", 16'h0048, waddr);
		@(posedge clk) card <= 1'b0;
		wait_pend(1'b0);
		@(posedge clk) ce <= 1'b0;
		@(posedge clk) pins <= pins ^ gpin[0];
		repeat (8) @(posedge clk);
		check("frozen pending", 16'h0000, {15'h0000, pending});
		@(posedge clk) ce <= 1'b1;
		wait_pend(1'b1);
		wait_pend(1'b0);
		$display("test entry done");
		@(posedge clk) auto_en <= 1'b0;
		wr(8'h1D, 8'h00);
		wr(8'h69, 8'h02);
		wr(8'h1C, 8'h01);
		@(posedge clk) sleep <= 1'b1;
		repeat (8) @(posedge clk);
		rd(8'h1C, 8'h01, "sleep gated flag");
		$display("test sleep done");
		give_verdict();
	end
endmodule
